// file: i2cmr_ctrl.sv
// Added by the designer: the address-and-strobe port.
module i2cmr_ctrl
	import i2cmr_pkg::*;
#(
	parameter int QUARTER = i2cmr_pkg::QUARTER_CYC
) (
	input  wire logic                        mclk_i,   // System clock
	input  wire logic                        nrst_i,   // Async reset, active low
	input  wire logic [i2cmr_pkg::ADDR_W-1:0] addr_i,   // Register address
	input  wire logic [7:0]                  wdata_i,  // Write data
	input  wire logic                        we_i,     // Write strobe
	input  wire logic                        re_i,     // Read strobe
	output logic      [7:0]                  rdata_o,  // Read data, cycle after re_i
	output logic                             irq_o,    // Level interrupt
	input  wire logic                        scl_i,    // SCL pin level
	output logic                             scl_o,    // SCL drive value
	output logic                             scl_oe_o, // SCL pulled low
	input  wire logic                        sda_i,    // SDA pin level
	output logic                             sda_o,    // SDA drive value
	output logic                             sda_oe_o  // SDA pulled low
);

	import i2cmr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and bit timing

	wire  [1:0] pin_b;
	wire  [1:0] pin_raw = {sda_i, scl_i};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_sync
			logic sync_a;
			logic sync_b;
			always_ff @(posedge mclk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					sync_a <= 1'b1;
					sync_b <= 1'b1;
				end
				else
				begin
					sync_a <= pin_raw[gi];
					sync_b <= sync_a;
				end
			end
			assign pin_b[gi] = sync_b;
		end
	endgenerate

	wire scl_s = pin_b[0];
	wire sda_s = pin_b[1];

	logic         ctl_en;
	logic         tick;
	i2cmr_state_e st;
	logic [1:0]   phase;
	logic [2:0]   bit_cnt;
	logic [7:0]   shifter;
	logic         scl_low;

	i2cmr_tick #(
		.DIV (QUARTER)
	) u_tick (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.run_i  (ctl_en),
		.tick_o (tick)
	);

	// Hold the high phase while a slave stretches SCL
	wire adv     = tick && !(phase == 2'd2 && !scl_s && !scl_low);
	wire last_q  = adv && (phase == 2'd3);
	wire byte_end = last_q && (bit_cnt == 3'd0);

	////////////////////////////////////////////////////////////////////////
	// Register decode

	wire wr_data = we_i && (addr_i == OFF_DATA);
	wire wr_ctrl = we_i && (addr_i == OFF_CTRL);
	wire wr_mask = we_i && (addr_i == OFF_IRQ_MASK);
	wire rd_data = re_i && (addr_i == OFF_DATA);
	wire rd_stat = re_i && (addr_i == OFF_STAT);
	wire rd_irq  = re_i && (addr_i == OFF_IRQ_STAT);
	wire rd_ctrl = re_i && (addr_i == OFF_CTRL);
	wire rd_mask = re_i && (addr_i == OFF_IRQ_MASK);

	logic [7:0] data_reg;
	logic       txe;
	logic       rxf;
	logic       ack_flag;
	logic       ten_flag;
	logic       rd_flag;
	logic       dss_flag;
	logic       not_ack_irq_flag;
	logic       addr_byte;
	logic       ctl_start;
	logic       ctl_stop;
	logic       ctl_nak;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic       txe_req_q;
	logic       sda_low;

	wire [7:0] stat_w = {txe, rxf, ack_flag, ten_flag, rd_flag, 1'b0, dss_flag, not_ack_irq_flag};
	wire [7:0] ctrl_w = {4'h0, ctl_nak, ctl_stop, ctl_start, ctl_en};

	wire [7:0] rd_mux = rd_data ? data_reg :
	                    rd_stat ? stat_w :
	                    rd_ctrl ? ctrl_w :
	                    rd_irq  ? {5'h00, irq_stat} :
	                    rd_mask ? {5'h00, irq_mask} : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Sequencer events

	wire go_start  = ctl_en && ctl_start && !txe && !wr_data;
	wire load_byte = (st == S_START) && last_q;
	wire next_tx   = !txe && !wr_data;
	wire rx_done   = (st == S_RX) && byte_end;
	wire nak_done  = (st == S_ACKT) && last_q && ctl_nak;
	wire stop_go   = ((st == S_WAIT) || (st == S_ACKR)) && ctl_stop;
	wire stop_done = (st == S_STOP) && last_q;
	// no request while receiving or sending a read address
	wire txe_req   = ctl_en && txe && (st != S_RX) && !((st == S_TX) && addr_byte && rd_flag);
	wire txe_evt   = txe_req && !txe_req_q;
	wire [2:0] irq_set = {nak_done, txe_evt, rx_done};
	wire [2:0] irq_clr = (rd_irq ? 3'h7 : 3'h0) | (wr_data ? 3'h2 : 3'h0);

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st        <= S_IDLE;
			phase     <= 2'd0;
			bit_cnt   <= 3'd7;
			shifter   <= 8'h00;
			scl_low   <= 1'b0;
			sda_low   <= 1'b0;
			addr_byte <= 1'b0;
		end
		else if (!ctl_en)
		begin
			st      <= S_IDLE;
			phase   <= 2'd0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
		end
		else if (st == S_IDLE || st == S_WAIT)
		begin
			if (tick && stop_go)
				st <= S_STOP;
			else if (tick && go_start)
				st <= S_START;
			else if (tick && st == S_WAIT && next_tx)
				st <= S_START;
			phase <= 2'd0;
		end
		else if (adv)
		begin
			phase <= phase + 2'd1;
			unique case (st)
				S_START:
				begin
					// SDA falls while SCL is high
					if (phase == 2'd0) sda_low <= (ctl_start) ? 1'b0 : sda_low;
					// Data byte with no START keeps SCL low, no stray pulse
					if (phase == 2'd1) scl_low <= ctl_start ? 1'b0 : scl_low;
					if (phase == 2'd2) sda_low <= ctl_start ? 1'b1 : sda_low;
					if (phase == 2'd3)
					begin
						// byte moves into the shift register
						scl_low   <= 1'b1;
						shifter   <= data_reg;
						addr_byte <= ctl_start;
						bit_cnt   <= 3'd7;
						st        <= S_TX;
					end
				end
				S_TX:
				begin
					if (phase == 2'd0) sda_low <= !shifter[7];
					if (phase == 2'd1) scl_low <= 1'b0;
					if (phase == 2'd3)
					begin
						scl_low <= 1'b1;
						shifter <= {shifter[6:0], 1'b0};
						bit_cnt <= bit_cnt - 3'd1;
						if (bit_cnt == 3'd0)
							st <= S_ACKR;
					end
				end
				S_ACKR:
				begin
					if (phase == 2'd0) sda_low <= 1'b0;
					if (phase == 2'd1) scl_low <= 1'b0;
					if (phase == 2'd3)
					begin
						scl_low   <= 1'b1;
						addr_byte <= 1'b0;
						bit_cnt   <= 3'd7;
						// read address turns the bus round
						if (addr_byte && rd_flag && ack_flag)
							st <= S_RX;
						else
							st <= S_WAIT;
					end
				end
				S_RX:
				begin
					if (phase == 2'd0) sda_low <= 1'b0;
					if (phase == 2'd1) scl_low <= 1'b0;
					if (phase == 2'd2) shifter <= {shifter[6:0], sda_s};
					if (phase == 2'd3)
					begin
						scl_low <= 1'b1;
						bit_cnt <= bit_cnt - 3'd1;
						if (bit_cnt == 3'd0)
							st <= S_ACKT;
					end
				end
				S_ACKT:
				begin
					// NAK releases SDA, ACK pulls it low
					if (phase == 2'd0) sda_low <= !ctl_nak;
					if (phase == 2'd1) scl_low <= 1'b0;
					if (phase == 2'd3)
					begin
						scl_low <= 1'b1;
						bit_cnt <= 3'd7;
						st      <= ctl_nak ? S_WAIT : S_RX;
					end
				end
				S_STOP:
				begin
					// SDA rises while SCL is high
					if (phase == 2'd0) sda_low <= 1'b1;
					if (phase == 2'd1) scl_low <= 1'b0;
					if (phase == 2'd2) sda_low <= 1'b0;
					if (phase == 2'd3) st <= S_IDLE;
				end
				default:
					st <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and flags

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			data_reg  <= DATA_RST;
			{txe, rxf, ack_flag, ten_flag, rd_flag} <= STAT_RST[7:3];
			dss_flag  <= STAT_RST[ST_DSS];
			not_ack_irq_flag      <= STAT_RST[ST_NOT_ACK_IRQ_FLAG];
			ctl_en    <= 1'b0;
			ctl_start <= 1'b0;
			ctl_stop  <= 1'b0;
			ctl_nak   <= 1'b0;
			irq_stat  <= 3'h0;
			irq_mask  <= 3'h0;
			txe_req_q <= 1'b0;
			rdata_o   <= 8'h00;
		end
		else
		begin
			rdata_o   <= rd_mux;
			txe_req_q <= txe_req;
			// Sticky events, set wins over clear
			irq_stat  <= (irq_stat & ~irq_clr) | irq_set;
			if (wr_mask) irq_mask <= wdata_i[2:0];
			if (wr_ctrl) ctl_en <= wdata_i[CTL_EN];
			// Command bits: a software set wins over the hardware clear
			ctl_start <= (wr_ctrl && wdata_i[CTL_START]) || (ctl_start && !load_byte);
			ctl_stop  <= (wr_ctrl && wdata_i[CTL_STOP]) || (ctl_stop && !stop_done);
			ctl_nak   <= (wr_ctrl && wdata_i[CTL_NAK]) || (ctl_nak && !nak_done);
			if (wr_data)
			begin
				data_reg <= wdata_i;
				txe      <= 1'b0;
			end
			else if (load_byte)
				txe <= 1'b1;
			if (load_byte && ctl_start)
			begin
				// first byte pattern marks a 10-bit address
				ten_flag <= (data_reg[7:3] == TEN_PREFIX);
				rd_flag  <= data_reg[0];
				dss_flag <= 1'b0;
			end
			else if (load_byte)
				dss_flag <= 1'b1;
			// ACK sampled in SCL high phase
			if (st == S_ACKR && adv && phase == 2'd2)
				ack_flag <= !sda_s;
			// received byte lands in data register
			if (rx_done)
			begin
				data_reg <= shifter;
				rxf      <= 1'b1;
				dss_flag <= 1'b1;
			end
			else if (rd_data)
				rxf <= 1'b0;
			if (nak_done)
				not_ack_irq_flag <= 1'b1;
			else if (st == S_STOP)
				not_ack_irq_flag <= 1'b0;
		end
	end

	assign irq_o    = |(irq_stat & irq_mask);
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_o = scl_low;
	assign sda_oe_o = sda_low;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_rx_last;
		(st == S_RX) && byte_end;
	endsequence

	sequence s_start_fall;
		(st == S_START) && adv && (phase == 2'd2) && ctl_start;
	endsequence

	property p_wr_clear;
		@(posedge mclk_i) disable iff (!nrst_i)
		wr_data |=> !txe && !irq_stat[IRQ_TXE] && (data_reg == $past(wdata_i));
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("data write left txe set");

	property p_stat_read;
		@(posedge mclk_i) disable iff (!nrst_i)
		rd_stat |=> (rdata_o == $past(stat_w)) && (rdata_o[ST_TAS] == 1'b0);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status read mismatch");

	property p_rx_irq;
		@(posedge mclk_i) disable iff (!nrst_i)
		s_rx_last |=> rxf && irq_stat[IRQ_RX] && (st == S_ACKT);
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("receive irq missing");

	property p_nak_irq;
		@(posedge mclk_i) disable iff (!nrst_i)
		nak_done |=> not_ack_irq_flag && irq_stat[IRQ_NAK] && !ctl_nak && (st == S_WAIT);
	endproperty
	a_nak_irq: assert property (p_nak_irq) else $error("nak irq missing");

	property p_nak_drive;
		@(posedge mclk_i) disable iff (!nrst_i)
		(st == S_ACKT) && (phase == 2'd2) && ctl_nak |-> !sda_oe_o && !scl_oe_o;
	endproperty
	a_nak_drive: assert property (p_nak_drive) else $error("nak bit not released");

	property p_stop_cond;
		@(posedge mclk_i) disable iff (!nrst_i)
		(st == S_STOP) && adv && (phase == 2'd2) |=> !sda_oe_o && !scl_oe_o ##1 (st == S_STOP);
	endproperty
	a_stop_cond: assert property (p_stop_cond) else $error("stop edge wrong");

	property p_start_cond;
		@(posedge mclk_i) disable iff (!nrst_i)
		s_start_fall |=> sda_oe_o && !scl_oe_o;
	endproperty
	a_start_cond: assert property (p_start_cond) else $error("start edge wrong");

	property p_ten_bit;
		@(posedge mclk_i) disable iff (!nrst_i)
		load_byte && ctl_start |=> (ten_flag == ($past(data_reg[7:3]) == TEN_PREFIX))
			&& (rd_flag == $past(data_reg[0])) && (st == S_TX);
	endproperty
	a_ten_bit: assert property (p_ten_bit) else $error("address byte flags wrong");

	property p_txe_quiet;
		@(posedge mclk_i) disable iff (!nrst_i)
		((st == S_RX) || ((st == S_TX) && addr_byte && rd_flag)) && !irq_stat[IRQ_TXE]
			|=> !irq_stat[IRQ_TXE];
	endproperty
	a_txe_quiet: assert property (p_txe_quiet) else $error("txe irq while receiving");

	property p_irq_merge;
		@(posedge mclk_i) disable iff (!nrst_i)
		$rose(irq_stat[IRQ_RX]) && irq_mask[IRQ_RX] |-> irq_o;
	endproperty
	a_irq_merge: assert property (p_irq_merge) else $error("irq output not raised");

endmodule : i2cmr_ctrl

// file: i2cmr_pkg.sv
//
// Contract
// - A set start bit makes the controller issue START and then shift out the loaded byte on SDA.
// - A set not-acknowledge bit makes the next received byte get a NAK instead of an ACK.
// - A fully received byte lands in the data register and raises the receive interrupt.
// - Driving the NAK after the last received byte raises the not-acknowledge interrupt.
// - A stop bit set by software makes the controller issue a STOP condition to end the transfer.
// - A 10-bit first address byte is 11110, two upper address bits, then the direction bit.
// - A 10-bit read runs START, W byte, ACK, 2nd byte, ACK, Sr, R byte, ACK, data, NAK, STOP.
// - The data register feeds and receives the hidden shift register, which software cannot reach.
// - Status is read-only: txe, rxf, ack, ten-bit, rd, target, data-select, nak-irq; resets to 80h.
// - While enabled, the transmit-empty flag is 1 whenever no byte waits in the data register.
// - Transmit-empty requests an interrupt except while receiving or sending an address with rd set.
// - Any write to the data register clears transmit-empty and its pending interrupt.
package i2cmr_pkg;

	localparam int          CLK_PERIOD_NS = 10;
	localparam int          BIT_TIME_NS   = 10000;
	// Quarter bit in system cycles, rounded down
	localparam int          QUARTER_CYC   = BIT_TIME_NS / (4 * CLK_PERIOD_NS);

	localparam int          ADDR_W        = 12;
	localparam logic [11:0] OFF_DATA      = 12'hF50;
	localparam logic [11:0] OFF_STAT      = 12'hF51;
	localparam logic [11:0] OFF_CTRL      = 12'hF52;
	localparam logic [11:0] OFF_IRQ_STAT  = 12'hF53;
	localparam logic [11:0] OFF_IRQ_MASK  = 12'hF54;

	localparam logic [7:0]  DATA_RST      = 8'h00;
	localparam logic [7:0]  STAT_RST      = 8'h80;

	localparam int          ST_TXE        = 7;
	localparam int          ST_RXF        = 6;
	localparam int          ST_ACK        = 5;
	localparam int          ST_TEN        = 4;
	localparam int          ST_RD         = 3;
	localparam int          ST_TAS        = 2;
	localparam int          ST_DSS        = 1;
	localparam int          ST_NOT_ACK_IRQ_FLAG       = 0;

	localparam int          CTL_EN        = 0;
	localparam int          CTL_START     = 1;
	localparam int          CTL_STOP      = 2;
	localparam int          CTL_NAK       = 3;

	localparam int          IRQ_RX        = 0;
	localparam int          IRQ_TXE       = 1;
	localparam int          IRQ_NAK       = 2;

	localparam logic [4:0]  TEN_PREFIX    = 5'h1E;

	typedef enum logic [7:0] {
		S_IDLE  = 8'h01,
		S_START = 8'h02,
		S_TX    = 8'h04,
		S_ACKR  = 8'h08,
		S_RX    = 8'h10,
		S_ACKT  = 8'h20,
		S_WAIT  = 8'h40,
		S_STOP  = 8'h80
	} i2cmr_state_e;

endpackage : i2cmr_pkg

// file: i2cmr_tick.sv
module i2cmr_tick #(
	parameter int DIV = 250
) (
	input  wire logic mclk_i,  // System clock
	input  wire logic nrst_i,  // Async reset, active low
	input  wire logic run_i,   // Divider runs
	output logic      tick_o   // One-cycle enable pulse
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt;
	wire           wrap = (cnt == LAST);

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cnt <= '0;
		else if (!run_i || wrap)
			cnt <= '0;
		else
			cnt <= cnt + CW'(1);
	end

	assign tick_o = run_i && wrap;

endmodule : i2cmr_tick

// file: i2cmr_slave.sv
module i2cmr_slave #(
	parameter logic [6:0] ADDR7  = 7'h50, // 7-bit address
	parameter logic [1:0] ADDR10 = 2'h2,  // Upper bits of 10-bit address
	parameter logic [7:0] TXB    = 8'h5C  // Byte sent on reads
) (
	input  wire logic   scl_i,     // SCL wire level
	input  wire logic   sda_i,     // SDA wire level
	input  wire logic   stretch_i, // Slow answers
	output logic        scl_oe_o,  // SCL pulled low
	output logic        sda_oe_o,  // SDA pulled low
	output logic        nak_o,     // Master refused our byte
	output logic [31:0] log_o,     // Acked bytes, newest low
	output int          n_byte_o,  // Bytes acked
	output int          n_start_o, // START conditions
	output int          n_stop_o   // STOP conditions
);
	timeunit 1ns;
	timeprecision 1ps;
	int         cnt;
	logic [7:0] sh;
	logic       sel;
	logic       first;
	logic       tx;
	logic       go_tx;

	initial
	begin
		{scl_oe_o, sda_oe_o, nak_o, sel, first, tx, go_tx} = '0;
		log_o = '0;
		{n_byte_o, n_start_o, n_stop_o, cnt} = '0;
	end

	////////////////////////////////////////////////////////////
	// start and restart
	// Ignore unknown levels settling at time zero
	always @(negedge sda_i)
		if (scl_i === 1'b1 && $time > 0)
		begin
			n_start_o++;
			cnt = -1;
			{first, tx, go_tx, sda_oe_o, nak_o} = 5'h10;
		end

	always @(posedge sda_i)
		if (scl_i === 1'b1 && $time > 0)
		begin
			n_stop_o++;
			{sel, tx} = 2'h0;
		end

	always @(posedge scl_i)
		if (cnt < 8)
			sh = {sh[6:0], sda_i};
		else if (tx)
			nak_o = sda_i;

	always @(negedge scl_i)
	begin
		cnt = (cnt == 8) ? 0 : cnt + 1;
		if (cnt == 0)
			tx = go_tx & sel & ~nak_o;
		sda_oe_o = 1'b0;
		if (cnt == 8 && !tx)
		begin
			if (first)
			begin
				sel = sh[7:1] == ADDR7 || sh[7:1] == {5'h1E, ADDR10};
				go_tx = sel & sh[0];
			end
			first = 1'b0;
			if (sel)
			begin
				sda_oe_o = 1'b1;
				n_byte_o++;
				log_o = {log_o[23:0], sh};
			end
		end
		else if (cnt < 8 && tx)
			sda_oe_o = ~TXB[7 - cnt];
	end

	// Slow mode holds SCL low
	always @(negedge scl_i)
		if (stretch_i)
		begin
			scl_oe_o = 1'b1;
			#400;
			scl_oe_o = 1'b0;
		end
endmodule : i2cmr_slave

// file: i2cmr_ctrl_tb.sv
module i2cmr_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import i2cmr_pkg::*;

	localparam logic [7:0] RBYTE = 8'h5C;
	localparam logic [7:0] A7RD  = 8'hA1;
	localparam logic [7:0] B10W  = 8'hF4;
	localparam logic [7:0] B10LO = 8'h5A;
	localparam logic [7:0] B10R  = 8'hF5;

	logic              mclk_i;
	logic              nrst_i;
	logic [ADDR_W-1:0] addr_i;
	logic [7:0]        wdata_i;
	logic              we_i;
	logic              re_i;
	logic [7:0]        rdata_o;
	logic              irq_o;
	logic              scl_o;
	logic              scl_oe_o;
	logic              sda_o;
	logic              sda_oe_o;
	logic              s_scl_oe;
	logic              s_sda_oe;
	logic              stretch;
	logic              s_nak;
	logic [31:0]       s_log;
	int                s_bytes;
	int                s_starts;
	int                s_stops;
	int                error_cnt;
	int                n_compared;
	wire               scl = ~(scl_oe_o | s_scl_oe);
	wire               sda = ~(sda_oe_o | s_sda_oe);

	i2cmr_ctrl #(.QUARTER(2)) DUT (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
	);

	i2cmr_slave #(.ADDR7(7'h50), .ADDR10(2'h2), .TXB(RBYTE)) SLV (
		.scl_i(scl), .sda_i(sda), .stretch_i(stretch), .scl_oe_o(s_scl_oe),
		.sda_oe_o(s_sda_oe), .nak_o(s_nak), .log_o(s_log), .n_byte_o(s_bytes),
		.n_start_o(s_starts), .n_stop_o(s_stops)
	);

	always #5 mclk_i = ~mclk_i;

	////////////////////////////////////////////////////////////
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t ns %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp, input string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask : chk1

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		we_i    <= 1'b1;
		@(posedge mclk_i);
		we_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		re_i   <= 1'b1;
		@(posedge mclk_i);
		re_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd

	// Kinds: 0 acked bytes, 1 stops, 2 master nak, 3 interrupt
	task automatic wait_for(input int kind, input int tgt, input string what);
		int n = 0;
		int v = 0;
		while (v < tgt && n < 5000)
		begin
			@(posedge mclk_i);
			#1;
			v = kind == 0 ? s_bytes : kind == 1 ? s_stops : kind == 2 ? int'(s_nak === 1'b1)
				: int'(irq_o === 1'b1);
			n++;
		end
		chk1(v >= tgt, 1'b1, what);
	endtask : wait_for

	task automatic final_report();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] v;
		rd(OFF_DATA, v);
		chk8(v, 8'h00, "data reset");
		rd(OFF_STAT, v);
		chk8(v, 8'h80, "status reset");
		wr(OFF_STAT, 8'h00);
		rd(OFF_STAT, v);
		chk8(v, 8'h80, "status write");
		rd(12'hF5F, v);
		chk8(v, 8'h00, "unmapped read");
		chk1(irq_o, 1'b0, "irq idle");
		chk1(scl & sda, 1'b1, "bus idle");
		chk1(scl_o | sda_o, 1'b0, "open drain level");
		rd(OFF_CTRL, v);
		chk8(v, 8'h00, "control reset");
		$display("Test reset done");
	endtask : t_reset

	task automatic t_read7();
		logic [7:0] v;
		wr(OFF_CTRL, 8'h01);
		wr(OFF_IRQ_MASK, 8'h05);
		wr(OFF_DATA, A7RD);
		rd(OFF_STAT, v);
		chk1(v[7], 1'b0, "txe after write");
		wr(OFF_CTRL, 8'h0B);
		wait_for(3, 1, "rx irq");
		rd(OFF_DATA, v);
		chk8(v, RBYTE, "byte read 7");
		wait_for(2, 1, "nak driven");
		@(negedge scl);
		rd(OFF_STAT, v);
		chk8(v & 8'hFD, 8'hA9, "status 7");
		rd(OFF_IRQ_STAT, v);
		chk8(v & 8'h05, 8'h05, "irq sources");
		rd(OFF_IRQ_STAT, v);
		chk8(v & 8'h05, 8'h00, "irq read clear");
		chk1(irq_o, 1'b0, "irq cleared");
		wr(OFF_CTRL, 8'h05);
		wait_for(1, 1, "stop 7");
		chk1(scl & sda, 1'b1, "bus free");
		chk8(s_log[7:0], A7RD, "address byte");
		rd(OFF_STAT, v);
		chk1(v[7], 1'b1, "txe idle");
		$display("Test read7 done");
	endtask : t_read7

	task automatic t_read10();
		logic [7:0] v;
		stretch <= 1'b1;
		wr(OFF_IRQ_MASK, 8'h02);
		wr(OFF_DATA, B10W);
		wr(OFF_CTRL, 8'h03);
		wait_for(3, 1, "txe irq");
		wr(OFF_IRQ_MASK, 8'h00);
		rd(OFF_STAT, v);
		chk1(v[7], 1'b1, "txe loaded");
		chk1(irq_o, 1'b0, "irq masked");
		wr(OFF_IRQ_MASK, 8'h02);
		wr(OFF_DATA, B10LO);
		rd(OFF_STAT, v);
		chk1(v[7], 1'b0, "txe cleared");
		chk1(irq_o, 1'b0, "txe irq cleared");
		wr(OFF_IRQ_MASK, 8'h05);
		wait_for(0, 3, "two bytes acked");
		wr(OFF_CTRL, 8'h0B);
		wr(OFF_DATA, B10R);
		wait_for(3, 1, "rx irq 10");
		rd(OFF_DATA, v);
		chk8(v, RBYTE, "byte read 10");
		wait_for(2, 1, "nak 10");
		@(negedge scl);
		rd(OFF_STAT, v);
		chk8(v & 8'hFD, 8'hB9, "status 10");
		wr(OFF_CTRL, 8'h05);
		wait_for(1, 2, "stop 10");
		chk8(s_log[23:16], B10W, "first byte");
		chk8(s_log[15:8], B10LO, "second byte");
		chk8(s_log[7:0], B10R, "read byte");
		chk8(8'(s_starts), 8'h03, "start count");
		$display("Test read10 done");
	endtask : t_read10

	////////////////////////////////////////////////////////////
	initial
	begin
		{mclk_i, nrst_i, we_i, re_i, stretch} = '0;
		addr_i = '0;
		wdata_i = '0;
		error_cnt = 0;
		n_compared = 0;
		repeat (10) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_read7();
		t_read10();
		final_report();
	end

	initial
	begin
		#500000;
		error_cnt++;
		$display("[FAIL] %0t ns watchdog expired", $time);
		final_report();
	end
endmodule : i2cmr_ctrl_tb
